/* File: dv/serial_host_model.sv */
/*
  serial engine stand-in: issues one-cycle register requests.
  assumes its owner calls the tasks and clock runs freely.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  // clock
  input wire logic clk_sys_i,
  // read answer
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  // request
  output var bus_opt_pkg::reg_req_t req_o
);
  // ==========================================================
  // request tasks, launched at falling edges
  initial req_o = '0;
  // one write pulse
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d, input logic hi);
    @(negedge clk_sys_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, hi_byte: hi};
    @(negedge clk_sys_i);
    req_o.wr = 1'b0;
  endtask : wr_byte
  // one read pulse; ok stays low without an answer in four cycles
  task automatic rd_byte(input logic [7:0] a, input logic hi,
                         output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk_sys_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00, hi_byte: hi};
    @(negedge clk_sys_i);
    req_o.rd = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = rdata_i;
      end else
        @(negedge clk_sys_i);
    end
  endtask : rd_byte
endmodule : serial_host_model
`default_nettype wire

/* File: dv/tb.sv */
/*
  bench for the option and range block, one task per scenario.
  assumes the serial engine model and the block's constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bus_opt_cfg.svh"
module tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] res = 8'h5A;
  logic [3:0] act = 4'hF;
  bus_opt_pkg::reg_req_t req;
  bus_opt_pkg::opt_bits_t opt;
  bus_opt_pkg::sense_range_t [3:0] sns;
  bus_opt_pkg::rail_range_t [3:0] rail;
  logic [7:0] rdata, nxt;
  logic rvalid, pfx, arm;
  logic [3:0] rsvd;
  int fail_count = 0;
  int n_compared = 0;
  // ==========================================================
  // clock and instances
  always #12.5 clk_sys_i = ~clk_sys_i;
  bus_options_and_range_config bus_options_and_range_config_i (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .req_i(req), .result_data_i(res), .ch_active_i(act),
    .rdata_o(rdata), .rvalid_o(rvalid), .next_addr_o(nxt), .opt_o(opt),
    .block_count_prefix_o(pfx), .timeout_armed_o(arm), .sense_range_o(sns),
    .rail_range_o(rail), .rail_rsvd_o(rsvd));
  serial_host_model serial_host_model_i (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
    .rvalid_i(rvalid), .req_o(req));
  // ==========================================================
  // shared tasks
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic hi);
    serial_host_model_i.wr_byte(a, d, hi);
  endtask : wr
  // read with bounded wait; no answer ends the run
  task automatic rd(input string nm, input logic [7:0] a, input logic hi, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    serial_host_model_i.rd_byte(a, hi, d, ok);
    check("rvalid_o", {15'h0000, ok}, 16'h0001);
    if (ok !== 1'b1)
      final_report();
    check(nm, {8'h00, d}, {8'h00, e});
  endtask : rd
  // ==========================================================
  // scenarios
  // reset values of every field
  task automatic t_reset;
    check("opt_o", {12'h000, opt}, 16'h0000);
    check("ranges", {sns, rail}, `RANGE_RESET);
    rd("opt rd", `OPT_ADDR, 1'b0, 8'h00);
    rd("range hi", `RANGE_ADDR, 1'b1, 8'h00);
    rd("range lo", `RANGE_ADDR, 1'b0, 8'h00);
  endtask : t_reset
  // each option bit alone, live at once
  task automatic t_opts;
    int i;
    for (i = 0; i < 4; i++) begin
      wr(`OPT_ADDR, 8'h01 << i, 1'b0);
      repeat (2) @(negedge clk_sys_i);
      check("opt_o", {12'h000, opt}, 16'h0001 << i);
      check("armed", {15'h0000, arm}, {15'h0000, i == 3});
      check("prefix", {15'h0000, pfx}, {15'h0000, i == 2});
      rd("opt rd", `OPT_ADDR, 1'b0, 8'h01 << i);
    end
  endtask : t_opts
  // every code on some channel, both bytes
  task automatic t_range;
    int i;
    wr(`RANGE_ADDR, 8'h1B, 1'b1);
    wr(`RANGE_ADDR, 8'hE4, 1'b0);
    repeat (2) @(negedge clk_sys_i);
    for (i = 0; i < 4; i++) begin
      check("sense", {14'h0000, sns[i]}, 16'(i));
      check("rail", {14'h0000, rail[i]}, 16'(3 - i));
    end
    check("rsvd", {12'h000, rsvd}, 16'h0001);
    rd("range hi", `RANGE_ADDR, 1'b1, 8'h1B);
    rd("range lo", `RANGE_ADDR, 1'b0, 8'hE4);
  endtask : t_range
  // only channel one active, skip then no skip
  task automatic t_skip;
    act = 4'h1;
    wr(`OPT_ADDR, 8'h00, 1'b0);
    rd("res", `RES_BASE, 1'b0, 8'h5A);
    check("next", {8'h00, nxt}, 16'h000F);
    rd("res off", 8'h0C, 1'b0, `FILL_BYTE);
    wr(`OPT_ADDR, 8'h02, 1'b0);
    rd("res", `RES_BASE, 1'b0, 8'h5A);
    check("next", {8'h00, nxt}, 16'h000C);
    rd("res off", 8'h0D, 1'b0, `FILL_BYTE);
    check("next", {8'h00, nxt}, 16'h000E);
  endtask : t_skip
  // every option bit set, ranges still as t_range left them, then reset again in mid-run
  task automatic t_rerst;
    wr(`OPT_ADDR, 8'h0F, 1'b0);
    repeat (2) @(negedge clk_sys_i);
    check("opt_o", {12'h000, opt}, 16'h000F);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    check("opt_o", {12'h000, opt}, 16'h0000);
    check("armed", {15'h0000, arm}, 16'h0000);
    check("ranges", {sns, rail}, `RANGE_RESET);
    rd("opt rd", `OPT_ADDR, 1'b0, 8'h00);
  endtask : t_rerst
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_reset();
    t_opts();
    t_range();
    t_skip();
    t_rerst();
    final_report();
  end
endmodule : tb
`default_nettype wire

/* File: hdl/bus_opt_cfg.svh */
/*
  constants for the serial option and range configuration block.
  assumes inclusion by bare name from hdl/.
*/
`ifndef BUS_OPT_CFG_SVH
`define BUS_OPT_CFG_SVH
// ==========================================================
// register addresses (device register pointer)
`define OPT_ADDR 8'h1C
`define RANGE_ADDR 8'h1D
// ==========================================================
// option bit positions
`define OPT_TIMEOUT_BIT 3
`define OPT_BYTECNT_BIT 2
`define OPT_NOSKIP_BIT 1
`define OPT_HISPEED_BIT 0
`define OPT_RESET 4'h0
`define RANGE_RESET 16'h0000
// ==========================================================
// result area: per channel address stride and base
`define RES_BASE 8'h0B
`define RES_LAST 8'h1A
`define RES_STRIDE 8'h04
`define FILL_BYTE 8'hFF
`define RAIL_CODE_RSVD 2'h3
`endif

/* File: hdl/bus_opt_pkg.sv */
/*
  types for the serial option and range configuration block.
  assumes no other package.
*/
package bus_opt_pkg;
  // sense range codes
  typedef enum logic [1:0] {
    SENSE_UNI100 = 2'h0,
    SENSE_BI100 = 2'h1,
    SENSE_BI50 = 2'h2,
    SENSE_RSVD = 2'h3
  } sense_range_t;
  // rail range codes
  typedef enum logic [1:0] {
    RAIL_UNI9 = 2'h0,
    RAIL_BI9 = 2'h1,
    RAIL_BI4P5 = 2'h2,
    RAIL_RSVD = 2'h3
  } rail_range_t;
  // option bits carried together
  typedef struct packed {
    logic timeout_en;
    logic byte_count_en;
    logic no_skip;
    logic fast_glitch_filter_sel;
  } opt_bits_t;
  // register access from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic hi_byte;
  } reg_req_t;
endpackage : bus_opt_pkg

/* File: hdl/bus_options_and_range_config.sv */
/*
  option bits and range selectors of a four channel power monitor,
  written and read by the serial engine through a simple register port.
  assumes the serial engine presents one byte access per request pulse.
*/
// Overview of operation
// R1 - time-out off after reset, used only while its option bit is one
// R2 - byte-count bit one puts a count before block read data
// R3 - skip bit zero: auto-increment jumps over inactive channel addresses
// R4 - skip bit one: auto-increment steps every address in order
// R5 - not skipping, reads of a disabled channel result return FF
// R6 - high-speed bit selects fast glitch filter widths, resets to zero
// R7 - two-bit sense range per channel, bits 15-8
// R8 - two-bit rail range per channel, bits 7-0, 00 and 01
// R9 - option writes act at once, reads show live values
// R10 - rail code 10 selects 4.5V bipolar, 11 is reserved
`timescale 1ns/1ps
`default_nettype none
`include "bus_opt_cfg.svh"
module bus_options_and_range_config (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port from serial engine
  input wire bus_opt_pkg::reg_req_t req_i,
  input wire logic [7:0] result_data_i,
  input wire logic [3:0] ch_active_i,
  // read answer
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // auto-increment
  output logic [7:0] next_addr_o,
  // option controls
  output bus_opt_pkg::opt_bits_t opt_o,
  output logic block_count_prefix_o,
  output logic timeout_armed_o,
  // range selectors
  output bus_opt_pkg::sense_range_t [3:0] sense_range_o,
  output bus_opt_pkg::rail_range_t [3:0] rail_range_o,
  output logic [3:0] rail_rsvd_o
);
  // ==========================================================
  // channel that owns a result address, 4 when none
  function automatic logic [2:0] addr_chan(input logic [7:0] a);
    logic [7:0] off;
    off = 8'h00;
    if (a < `RES_BASE || a > `RES_LAST) begin
      addr_chan = 3'h4;
    end else begin
      off = a - `RES_BASE;
      addr_chan = {1'b0, off[1:0]};
    end
  endfunction : addr_chan

  bus_opt_pkg::opt_bits_t opt_reg;
  logic [15:0] range_q;
  logic [7:0] next_addr_next;
  logic [2:0] rd_chan;
  logic rd_dead;
  logic [2:0] next_chan;

  // ==========================================================
  // option register, effective immediately
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      opt_reg <= bus_opt_pkg::opt_bits_t'(`OPT_RESET); // see R1 see R6
    end else if (req_i.wr && req_i.addr == `OPT_ADDR) begin
      opt_reg <= bus_opt_pkg::opt_bits_t'(req_i.wdata[3:0]); // see R9
    end
  end

  // range register storage
  range_store range_store_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .we_i(req_i.wr && req_i.addr == `RANGE_ADDR),
    .hi_i(req_i.hi_byte),
    .wdata_i(req_i.wdata),
    .q_o(range_q)
  );

  // ==========================================================
  // read path
  assign rd_chan = addr_chan(req_i.addr);
  assign rd_dead = (rd_chan != 3'h4) && !ch_active_i[rd_chan[1:0]];
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        if (req_i.addr == `OPT_ADDR) begin
          rdata_o <= {4'h0, opt_reg}; // see R9
        end else if (req_i.addr == `RANGE_ADDR) begin
          rdata_o <= req_i.hi_byte ? range_q[15:8] : range_q[7:0];
        end else if (rd_dead) begin
          rdata_o <= `FILL_BYTE; // see R5
        end else begin
          rdata_o <= result_data_i;
        end
      end
    end
  end

  // ==========================================================
  // auto-increment with optional skip of inactive channels
  always_comb begin
    logic [7:0] a;
    logic [2:0] c;
    a = req_i.addr + 8'h01;
    c = addr_chan(a);
    if (!opt_reg.no_skip) begin
      // see R3
      for (int i = 0; i < 16; i++) begin
        c = addr_chan(a);
        if (c != 3'h4 && !ch_active_i[c[1:0]]) begin
          a = a + 8'h01;
        end
      end
    end
    next_addr_next = a; // see R4
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      next_addr_o <= 8'h00;
    end else if (req_i.rd || req_i.wr) begin
      next_addr_o <= next_addr_next;
    end
  end

  // ==========================================================
  // decoded outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      opt_o <= '0;
      block_count_prefix_o <= 1'b0;
      timeout_armed_o <= 1'b0;
      sense_range_o <= '{default: bus_opt_pkg::SENSE_UNI100};
      rail_range_o <= '{default: bus_opt_pkg::RAIL_UNI9};
      rail_rsvd_o <= 4'h0;
    end else begin
      opt_o <= opt_reg; // see R6
      block_count_prefix_o <= opt_reg.byte_count_en; // see R2
      timeout_armed_o <= opt_reg.timeout_en; // see R1
      for (int i = 0; i < 4; i++) begin
        sense_range_o[i] <= bus_opt_pkg::sense_range_t'(range_q[15-2*i -: 2]); // see R7
        rail_range_o[i] <= bus_opt_pkg::rail_range_t'(range_q[7-2*i -: 2]); // see R8 see R10
        rail_rsvd_o[i] <= range_q[7-2*i -: 2] == `RAIL_CODE_RSVD; // see R10
      end
    end
  end

  // ==========================================================
  // checks
  // channel owning the next pointer, for the skip check
  assign next_chan = addr_chan(next_addr_next);

  // time-out control: off out of reset, then one cycle behind its bit
  timeout_rst_a: assert property (@(posedge clk_sys_i) // see R1
    $rose(rst_n_i) |-> !timeout_armed_o)
    else $error("timeout armed at reset");
  timeout_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R1
    timeout_armed_o == $past(opt_reg.timeout_en))
    else $error("timeout not following bit");

  // block count prefix follows its bit
  count_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R2
    block_count_prefix_o == $past(opt_reg.byte_count_en))
    else $error("byte count wrong");

  // option register: writes land at once, reads show the live value
  opt_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R9
    req_i.wr && req_i.addr == `OPT_ADDR |=> opt_reg == $past(req_i.wdata[3:0]))
    else $error("option write lost");
  opt_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R9
    req_i.rd && req_i.addr == `OPT_ADDR |=> rdata_o == {4'h0, $past(opt_reg)})
    else $error("option read not live");

  // result reads of an inactive channel give the fill byte
  dead_fill_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R5
    req_i.rd && rd_dead && req_i.addr != `OPT_ADDR && req_i.addr != `RANGE_ADDR
    |=> rdata_o == `FILL_BYTE)
    else $error("inactive read not FF");

  // pointer stepping with and without skipping
  noskip_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R4
    (req_i.rd || req_i.wr) && opt_reg.no_skip |=> next_addr_o == $past(req_i.addr) + 8'h01)
    else $error("no-skip step wrong");
  skip_live_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R3
    (req_i.rd || req_i.wr) && !opt_reg.no_skip && next_chan != 3'h4
    |-> ch_active_i[next_chan[1:0]])
    else $error("skip landed on inactive");

  // glitch filter select: clear out of reset, then follows its bit
  hs_reset_a: assert property (@(posedge clk_sys_i) // see R6
    $rose(rst_n_i) |-> !opt_o.fast_glitch_filter_sel)
    else $error("high speed set at reset");
  hs_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R6
    opt_o.fast_glitch_filter_sel == $past(opt_reg.fast_glitch_filter_sel))
    else $error("high speed wrong");

  // range high byte write, fields of channels one and four, and the reserved rail flag
  range_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R7
    req_i.wr && req_i.addr == `RANGE_ADDR && req_i.hi_byte
    |=> range_q[15:8] == $past(req_i.wdata))
    else $error("range byte lost");
  rail_field_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R7 see R8
    ##1 rail_range_o[0] == $past(range_q[7:6]) && sense_range_o[0] == $past(range_q[15:14]))
    else $error("range field wrong");
  sense_last_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R7 see R8
    sense_range_o[3] == $past(range_q[9:8]) && rail_range_o[3] == $past(range_q[1:0]))
    else $error("channel four range wrong");
  rsvd_flag_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R10
    rail_rsvd_o[0] == ($past(range_q[7:6]) == `RAIL_CODE_RSVD))
    else $error("reserved rail flag wrong");

  // main scenarios
  cv_opt_wr: cover property (@(posedge clk_sys_i) req_i.wr && req_i.addr == `OPT_ADDR);
  cv_fill: cover property (@(posedge clk_sys_i) req_i.rd && rd_dead);
  cv_rsvd: cover property (@(posedge clk_sys_i) rail_rsvd_o != 4'h0);
  cv_hop: cover property (@(posedge clk_sys_i)
    (req_i.rd || req_i.wr) && next_addr_next > req_i.addr + 8'h01);
  cv_noskip_fill: cover property (@(posedge clk_sys_i) req_i.rd && rd_dead && opt_reg.no_skip);
endmodule : bus_options_and_range_config
`default_nettype wire

/* File: hdl/range_store.sv */
/*
  holds the 16-bit range selector register, byte writable, registered read.
  assumes the caller decodes the address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bus_opt_cfg.svh"
module range_store (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // write port
  input wire logic we_i,
  input wire logic hi_i,
  input wire logic [7:0] wdata_i,
  // contents
  output logic [15:0] q_o
);
  // ==========================================================
  // storage
  logic [15:0] range_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      range_reg <= `RANGE_RESET;
    end else if (we_i) begin
      if (hi_i) begin
        range_reg[15:8] <= wdata_i;
      end else begin
        range_reg[7:0] <= wdata_i;
      end
    end
  end
  assign q_o = range_reg;
endmodule : range_store
`default_nettype wire
